// *** verilog/tdiv_pkg.sv ***
package tdiv_pkg;

  // ---------------------------------------------------------------------
  // Sizes and clock
  // ---------------------------------------------------------------------
  localparam int CNT_W         = 8;
  localparam int NCH           = 2;
  localparam int CLK_PERIOD_NS = 40;

  // ---------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [NCH-1:0][7:0] ADDR_CTRL = {8'h08, 8'h00};
  localparam logic [NCH-1:0][7:0] ADDR_CMP  = {8'h0c, 8'h04};
  localparam logic [7:0]          ADDR_CFG  = 8'h10;
  localparam logic [7:0]          ADDR_STAT = 8'h14;

  // Field positions outside the control byte
  localparam int CFG_TAP_BIT  = 0;
  localparam int STAT_FF_LSB  = 16;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CMP_RST  = 8'h00;

  // ---------------------------------------------------------------------
  // Mode and source codes
  // ---------------------------------------------------------------------
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_DIV   = 3'h1;
  localparam logic [2:0] MODE_PWM   = 3'h2;
  localparam logic [2:0] MODE_PAIR  = 3'h3;
  localparam logic [2:0] SEL_PIN    = 3'h7;

  // Prescaler exponents: slow tap, three fast taps, low-frequency divider
  localparam int PRE_W = 11;
  localparam int TAP_E1 = 7;
  localparam int TAP_E2 = 5;
  localparam int TAP_E3 = 3;
  localparam int FS_E  = 3;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic       ff_init;
    logic [2:0] clk_sel;
    logic       run;
    logic [2:0] mode;
  } tdiv_ctrl_t;

  typedef struct packed {
    tdiv_ctrl_t [NCH-1:0]            ctrl;
    logic       [NCH-1:0][CNT_W-1:0] cmp;
    logic                            tap_sel;
    logic       [31:0]               prdata;
    logic                            slverr;
    logic       [NCH-1:0]            pin_prev;
  } tdiv_regs_t;

endpackage : tdiv_pkg

// *** verilog/tdiv_presc.sv ***
`timescale 1ns/10ps
module tdiv_presc
  import tdiv_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       tap_sel_i,
  input  wire logic       low_speed_i,
  input  wire logic       low_freq_tick_i,
  output logic      [7:0] src_tick_o
);

  typedef struct packed {
    logic [PRE_W-1:0] div;
    logic [FS_E-1:0]  fs_div;
  } tdiv_pre_st_t;

  tdiv_pre_st_t st_r;
  tdiv_pre_st_t st_nxt;
  logic [3:0]   tap;
  logic         fs_tick;

  // ---------------------------------------------------------------------
  // Free-running dividers
  // ---------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.div = PRE_W'(st_r.div + 1'b1);
    if (low_freq_tick_i) begin
      st_nxt.fs_div = FS_E'(st_r.fs_div + 1'b1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // One tap per exponent: a tick when the low bits are all ones
  localparam int TAP_E [4] = '{PRE_W, TAP_E1, TAP_E2, TAP_E3};
  for (genvar t = 0; t < 4; t++) begin : g_tap
    assign tap[t] = &st_r.div[TAP_E[t]-1:0];
  end

  assign fs_tick = low_freq_tick_i & (&st_r.fs_div);

  // Low-speed leaves only the slow sources alive
  assign src_tick_o[0] = (tap_sel_i | low_speed_i) ? fs_tick : tap[0];
  assign src_tick_o[1] = ~low_speed_i & tap[1];
  assign src_tick_o[2] = ~low_speed_i & tap[2];
  assign src_tick_o[3] = ~low_speed_i & tap[3];
  assign src_tick_o[4] = low_freq_tick_i;
  assign src_tick_o[5] = ~low_speed_i & st_r.div[0];
  assign src_tick_o[6] = ~low_speed_i;
  assign src_tick_o[7] = 1'b0; // Pin source is picked in the top

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  tap_rate_a: assert property (tap[3] |-> ##8 tap[3])
    else $error("Fast tap not spaced by eight clocks");
  slow_only_a: assert property (low_speed_i |-> src_tick_o[3:1] == 3'h0)
    else $error("Fast tap alive in low-speed mode");

endmodule : tdiv_presc

// *** verilog/tdiv_chan.sv ***
`timescale 1ns/10ps
module tdiv_chan
  import tdiv_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             run_i,
  input  wire logic             inc_i,
  input  wire logic             hit_i,
  input  wire logic             tgl_en_i,
  input  wire logic             ff_wr_i,
  input  wire logic             ff_val_i,
  output logic      [CNT_W-1:0] cnt_o,
  output logic                  ff_o,
  output logic                  irq_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             ff;
    logic             irq;
  } tdiv_ch_st_t;

  tdiv_ch_st_t st_r;
  tdiv_ch_st_t st_nxt;

  // ---------------------------------------------------------------------
  // Counter and output flip-flop
  // ---------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.irq = run_i & hit_i;
    if (!run_i) begin
      st_nxt.cnt = '0;
    end else if (hit_i) begin
      st_nxt.cnt = '0;
    end else if (inc_i) begin
      st_nxt.cnt = CNT_W'(st_r.cnt + 1'b1);
    end
    // A software load wins; the sequence rules keep the two apart
    if (ff_wr_i) begin
      st_nxt.ff = ff_val_i;
    end else if (run_i && hit_i && tgl_en_i) begin
      st_nxt.ff = ~st_r.ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cnt_o = st_r.cnt;
  assign ff_o  = st_r.ff;
  assign irq_o = st_r.irq;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  div_toggle_a: assert property (run_i && hit_i && tgl_en_i && !ff_wr_i
    |=> ff_o != $past(ff_o) && cnt_o == '0 && irq_o)
    else $error("Divider match did not toggle and clear");
  stop_clr_a: assert property (!run_i |=> cnt_o == '0 && !irq_o)
    else $error("Stopped channel kept its count");
  stop_hold_a: assert property (!run_i && !ff_wr_i |=> $stable(ff_o))
    else $error("Output flip-flop moved while stopped");

endmodule : tdiv_chan

// *** verilog/tdiv_top.sv ***
`timescale 1ns/10ps

// What this block does
// - Timer counts ticks, match interrupts and clears
// - Event mode counts falling edges of pin
// - Event match interrupts, clears, waits next edge
// - Divider match toggles flip-flop, clears, interrupts
// - Divider pin is inverse of flip-flop
// - Flip-flop loads written bit; reset clears it
// - Stopped divider pin holds its level
// - Compare writes act at once, no shadow
// - Internal sources by select and speed mode
// - Cascaded pair uses lower channel's select
// - Mode field codes the operating modes
// - Select code 111 picks the pin
module tdiv_top
  import tdiv_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  input  wire logic [NCH-1:0]       event_input_pin_i,
  input  wire logic                 low_freq_tick_i,
  input  wire logic                 low_speed_i,
  output logic      [NCH-1:0]       divider_out_pin_o,
  output logic      [NCH-1:0]       match_irq_o
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  tdiv_regs_t                      regs_r;
  tdiv_regs_t                      regs_nxt;
  logic                            setup;
  logic                            wr_acc;
  logic                            casc;
  logic       [7:0]                src_tick;
  logic       [NCH-1:0]            pin_fall;
  logic       [NCH-1:0]            tick;
  logic       [NCH-1:0]            run;
  logic       [NCH-1:0]            bit8;
  logic       [NCH-1:0]            inc;
  logic       [NCH-1:0]            hit;
  logic       [NCH-1:0]            ff_wr;
  logic       [NCH-1:0]            ff;
  logic       [NCH-1:0]            irq;
  logic       [NCH-1:0][2:0]       sel;
  logic       [NCH-1:0][CNT_W-1:0] cnt;
  logic       [NCH-1:0][CNT_W-1:0] nxt8;
  logic       [2*CNT_W-1:0]        cnt16;
  logic       [2*CNT_W-1:0]        cmp16;
  logic                            hit16;
  logic       [31:0]               stat_word;

  // ---------------------------------------------------------------------
  // APB phases
  // ---------------------------------------------------------------------
  // Zero wait states: read data is latched in the setup cycle
  assign setup  = psel_i & ~penable_i;
  assign wr_acc = psel_i & penable_i & pwrite_i;

  assign pready_o  = 1'b1;
  assign prdata_o  = regs_r.prdata;
  // Error only shows in the access phase it belongs to
  assign pslverr_o = regs_r.slverr & psel_i & penable_i;

  // Live state for software: counters and output flip-flops
  always_comb begin
    stat_word = '0;
    stat_word[2*CNT_W-1:0] = cnt16;
    stat_word[STAT_FF_LSB +: NCH] = ff;
  end

  // ---------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------
  always_comb begin
    regs_nxt = regs_r;
    regs_nxt.pin_prev = event_input_pin_i;
    // Read path, decoded in the setup cycle
    if (setup) begin
      regs_nxt.prdata = 32'h0;
      regs_nxt.slverr = 1'b1;
      if (paddr_i == ADDR_CFG) begin
        regs_nxt.prdata[CFG_TAP_BIT] = regs_r.tap_sel;
        regs_nxt.slverr = 1'b0;
      end
      if (paddr_i == ADDR_STAT) begin
        regs_nxt.prdata = stat_word;
        regs_nxt.slverr = 1'b0;
      end
      for (int c = 0; c < NCH; c++) begin
        if (paddr_i == ADDR_CTRL[c]) begin
          regs_nxt.prdata[7:0] = regs_r.ctrl[c];
          regs_nxt.slverr = 1'b0;
        end
        if (paddr_i == ADDR_CMP[c]) begin
          regs_nxt.prdata[CNT_W-1:0] = regs_r.cmp[c];
          regs_nxt.slverr = 1'b0;
        end
      end
    end
    // Write path, taken in the access cycle
    if (wr_acc) begin
      if (paddr_i == ADDR_CFG) begin
        regs_nxt.tap_sel = pwdata_i[CFG_TAP_BIT];
      end
      for (int c = 0; c < NCH; c++) begin
        if (paddr_i == ADDR_CTRL[c]) begin
          regs_nxt.ctrl[c] = pwdata_i[7:0];
        end
        // No shadow stage: the new compare is live next cycle
        if (paddr_i == ADDR_CMP[c]) begin
          regs_nxt.cmp[c] = pwdata_i[CNT_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      regs_r          <= '0;
      regs_r.ctrl     <= {NCH{CTRL_RST}};
      regs_r.cmp      <= {NCH{CMP_RST}};
      regs_r.pin_prev <= '1;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------------
  tdiv_presc u_presc (
    .ref_clk_i       (ref_clk_i),
    .sys_rst_i       (sys_rst_i),
    .tap_sel_i       (regs_r.tap_sel),
    .low_speed_i     (low_speed_i),
    .low_freq_tick_i (low_freq_tick_i),
    .src_tick_o      (src_tick)
  );

  // ---------------------------------------------------------------------
  // Cascade
  // ---------------------------------------------------------------------
  // Upper channel in a wide mode joins the pair; only the plain
  // wide count is carried out, other wide modes count the same way
  assign casc  = regs_r.ctrl[1].mode[2];
  assign cnt16 = {cnt[1], cnt[0]};
  assign cmp16 = {regs_r.cmp[1], regs_r.cmp[0]};
  assign hit16 = tick[0] && ((2*CNT_W)'(cnt16 + 1'b1) == cmp16);

  // ---------------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    // Pin is sampled each clock; a high then low pair is one edge
    assign pin_fall[c] = regs_r.pin_prev[c] & ~event_input_pin_i[c];

    // Pair takes its source from the lower channel
    assign sel[c] = casc ? regs_r.ctrl[0].clk_sel
                         : regs_r.ctrl[c].clk_sel;

    // Code 111 swaps the prescaler for the pin
    assign tick[c] = (sel[c] == SEL_PIN) ? pin_fall[casc ? 0 : c]
                                         : src_tick[sel[c]];

    assign run[c] = casc ? regs_r.ctrl[1].run : regs_r.ctrl[c].run;

    // Eight-bit counting modes; PWM and reserved codes stay idle
    assign bit8[c] = ~casc && (regs_r.ctrl[c].mode == MODE_TIMER ||
                               regs_r.ctrl[c].mode == MODE_DIV);

    assign nxt8[c] = CNT_W'(cnt[c] + 1'b1);

    if (c == 0) begin : g_lo
      assign inc[c] = casc ? tick[0] : bit8[c] & tick[c];
    end else begin : g_hi
      // Upper byte steps on the lower byte's carry
      assign inc[c] = casc ? tick[0] && cnt[0] == {CNT_W{1'b1}}
                           : bit8[c] & tick[c];
    end

    // Match checked on the value after the step
    assign hit[c] = casc ? hit16
                         : bit8[c] & tick[c] &
                           (nxt8[c] == regs_r.cmp[c]);

    assign ff_wr[c] = wr_acc && paddr_i == ADDR_CTRL[c];

    tdiv_chan u_chan (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .run_i     (run[c]),
      .inc_i     (inc[c]),
      .hit_i     (hit[c]),
      .tgl_en_i  (bit8[c] && regs_r.ctrl[c].mode == MODE_DIV),
      .ff_wr_i   (ff_wr[c]),
      .ff_val_i  (pwdata_i[7]),
      .cnt_o     (cnt[c]),
      .ff_o      (ff[c]),
      .irq_o     (irq[c])
    );

    // Pin shows the inverse of the flip-flop, stopped or not
    assign divider_out_pin_o[c] = ~ff[c];

    // In a pair only the upper channel reports the match
    assign match_irq_o[c] = irq[c] & ~(casc && c == 0);
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  tmr_match_a: assert property (run[0] && bit8[0] && tick[0]
    && sel[0] != SEL_PIN && nxt8[0] == regs_r.cmp[0]
    |=> cnt[0] == '0 && match_irq_o[0])
    else $error("Timer match did not clear and interrupt");

  evt_count_a: assert property (run[1] && bit8[1]
    && sel[1] == SEL_PIN && pin_fall[1] && !hit[1]
    |=> cnt[1] == CNT_W'($past(cnt[1]) + 1'b1))
    else $error("Event edge not counted");

  evt_hold_a: assert property (run[1] && bit8[1]
    && sel[1] == SEL_PIN && !pin_fall[1]
    |=> $stable(cnt[1]))
    else $error("Event counter moved without an edge");

  pin_inv_a: assert property (divider_out_pin_o == ~ff)
    else $error("Divider pin not inverse of flip-flop");

  ff_load_a: assert property (ff_wr[1]
    |=> ff[1] == $past(pwdata_i[7]))
    else $error("Flip-flop did not take the written bit");

  cmp_now_a: assert property (wr_acc && paddr_i == ADDR_CMP[0]
    |=> regs_r.cmp[0] == $past(pwdata_i[CNT_W-1:0]))
    else $error("Compare write not immediate");

  casc_carry_a: assert property (casc && run[1] && tick[0]
    && cnt[0] == {CNT_W{1'b1}} && !hit16
    |=> cnt[1] == CNT_W'($past(cnt[1]) + 1'b1) && cnt[0] == '0)
    else $error("Pair carry lost");

  unmapped_a: assert property (setup && paddr_i == 8'h18
    |=> pslverr_o || !penable_i)
    else $error("Unmapped access not flagged");

  div_hit_c: cover property (run[0] && hit[0]
    && regs_r.ctrl[0].mode == MODE_DIV);
  evt_hit_c: cover property (run[1] && hit[1] && sel[1] == SEL_PIN);
  casc_hit_c: cover property (casc && run[1] && hit16);
  stop_c: cover property ($fell(run[0]) && divider_out_pin_o[0]);

endmodule : tdiv_top

// *** tb/tdiv_evsrc.sv ***
`timescale 1ns/10ps
// -----------------------------------------------------------------------
// Event source standing on the two event pins
// -----------------------------------------------------------------------
module tdiv_evsrc (
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [1:0] fire_i,
  input  wire logic [3:0] hold_i,
  output logic      [1:0] pin_o,
  output logic      [1:0] busy_o
);
  logic [1:0][4:0] cnt_r;
  logic [1:0][1:0] st_r;
  logic      [4:0] hold;

  // Each level lasts at least two cycles, slower when asked
  assign hold = (hold_i < 4'h2) ? 5'h02 : {1'b0, hold_i};

  // One low pulse per request: idle high, low, high, idle
  always_ff @(posedge ref_clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (sys_rst_i) begin
        st_r[c]  <= 2'h0;
        cnt_r[c] <= 5'h00;
      end else if (st_r[c] == 2'h0) begin
        if (fire_i[c]) begin
          st_r[c]  <= 2'h1;
          cnt_r[c] <= hold;
        end
      end else if (cnt_r[c] > 5'h01) begin
        cnt_r[c] <= cnt_r[c] - 5'h01;
      end else begin
        st_r[c]  <= (st_r[c] == 2'h1) ? 2'h2 : 2'h0;
        cnt_r[c] <= hold;
      end
    end
  end

  // Pin rests high between pulses, as with a pull-up
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      pin_o[c]  = (st_r[c] != 2'h1);
      busy_o[c] = (st_r[c] != 2'h0);
    end
  end
endmodule : tdiv_evsrc

// *** tb/tdiv_top_test.sv ***
`timescale 1ns/10ps
module tdiv_top_test
  import tdiv_pkg::*;
();
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, lf_tick;
  logic        low_speed, rerr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0]  ev_pin, dpin, irq, fire, busy;
  logic [3:0]  hold;
  int          fail_count, n_tests, n;
  int          lf_div = 0;

  tdiv_top i_tdiv_top (.ref_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .event_input_pin_i(ev_pin),
    .low_freq_tick_i(lf_tick), .low_speed_i(low_speed),
    .divider_out_pin_o(dpin), .match_irq_o(irq));
  tdiv_evsrc i_tdiv_evsrc (.ref_clk_i(clk), .sys_rst_i(rst), .fire_i(fire),
    .hold_i(hold), .pin_o(ev_pin), .busy_o(busy));

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  // Low-frequency tick every ten cycles, unrelated to the prescaler
  always @(posedge clk) begin
    lf_div  <= (lf_div == 9) ? 0 : lf_div + 1;
    lf_tick <= (lf_div == 9);
  end

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // One APB transfer; data and error taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      fail_count++;
      close_out();
    end
  endtask : apb

  function automatic logic [31:0] cw(logic f, logic [2:0] s, logic r,
                                     logic [2:0] m);
    return {24'h0, f, s, r, m};
  endfunction : cw

  // Counts edges until the interrupt is seen or the bound runs out
  task automatic wait_irq(input int ch, input int bound, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (irq[ch] !== 1'b1 && c < bound);
  endtask : wait_irq

  task automatic ev_pulse(input int ch, input logic [3:0] h, input logic w);
    int k;
    @(posedge clk);
    hold     <= h;
    fire[ch] <= 1'b1;
    @(posedge clk);
    fire[ch] <= 1'b0;
    k = 0;
    // Busy only shows after this edge, so look from the next one on
    if (w) begin
      do begin
        @(posedge clk);
        k++;
      end while (busy[ch] !== 1'b0 && k < 40);
    end
    if (k >= 40) begin
      fail_count++;
      close_out();
    end
  endtask : ev_pulse

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset();
    for (int c = 0; c < NCH; c++) begin
      apb(1'b0, ADDR_CTRL[c], 32'h0);
      check("ctrl reset", {24'h0, CTRL_RST}, rdat);
      apb(1'b0, ADDR_CMP[c], 32'h0);
      check("cmp reset", {24'h0, CMP_RST}, rdat);
    end
    apb(1'b0, ADDR_STAT, 32'h0);
    check("stat reset", 32'h0, rdat);
    check("pins after reset", 32'h3, {30'h0, dpin});
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped error", 32'h1, {31'h0, rerr});
    check("unmapped data", 32'h0, rdat);
  endtask : t_reset

  task automatic t_sources();
    logic [2:0] sels[6] = '{3'h6, 3'h5, 3'h3, 3'h2, 3'h1, 3'h0};
    int per[6]  = '{2, 4, 16, 64, 256, 4096};
    apb(1'b1, ADDR_CMP[0], 32'h2);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ADDR_CTRL[0], cw(1'b0, sels[i], 1'b1, MODE_TIMER));
      wait_irq(0, 8200, n);
      wait_irq(0, 8200, n);
      check("timer period", per[i], n);
      apb(1'b1, ADDR_CTRL[0], 32'h0);
    end
    apb(1'b1, ADDR_CFG, 32'h1);
    for (int s = 0; s < 2; s++) begin
      low_speed <= (s == 1);
      apb(1'b1, ADDR_CTRL[0], cw(1'b0, 3'h0, 1'b1, MODE_TIMER));
      wait_irq(0, 400, n);
      wait_irq(0, 400, n);
      check("slow tap period", 32'd160, n);
      apb(1'b1, ADDR_CTRL[0], 32'h0);
    end
    apb(1'b1, ADDR_CTRL[0], cw(1'b0, 3'h3, 1'b1, MODE_TIMER));
    wait_irq(0, 200, n);
    check("fast tap in low speed", 32'd200, n);
    apb(1'b1, ADDR_CTRL[0], 32'h0);
    apb(1'b1, ADDR_CFG, 32'h0);
    low_speed <= 1'b0;
  endtask : t_sources

  task automatic t_stop();
    apb(1'b1, ADDR_CMP[0], 32'hc8);
    apb(1'b1, ADDR_CTRL[0], cw(1'b0, 3'h6, 1'b1, MODE_TIMER));
    repeat (20) @(posedge clk);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("running count", 32'h1, {31'h0, rdat[7:0] != 8'h00});
    apb(1'b1, ADDR_CTRL[0], cw(1'b0, 3'h6, 1'b0, MODE_TIMER));
    apb(1'b0, ADDR_STAT, 32'h0);
    check("stopped count", 32'h0, {24'h0, rdat[7:0]});
    wait_irq(0, 300, n);
    check("no match when stopped", 32'd300, n);
  endtask : t_stop

  task automatic t_event();
    apb(1'b1, ADDR_CMP[1], 32'h3);
    apb(1'b1, ADDR_CTRL[1], cw(1'b0, SEL_PIN, 1'b1, MODE_TIMER));
    ev_pulse(1, 4'h2, 1'b1);
    ev_pulse(1, 4'h5, 1'b1);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("event count", 32'h2, {24'h0, rdat[15:8]});
    ev_pulse(1, 4'h2, 1'b0);
    wait_irq(1, 40, n);
    check("event match", 32'h1, {31'h0, n < 40});
    repeat (6) @(posedge clk);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("event cleared", 32'h0, {24'h0, rdat[15:8]});
    ev_pulse(1, 4'h3, 1'b1);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("event restart", 32'h1, {24'h0, rdat[15:8]});
    apb(1'b1, ADDR_CTRL[1], 32'h0);
  endtask : t_event

  // Divider toggles every four ticks of fc/2^3, so every 32 cycles
  task automatic t_div();
    logic p;
    logic f;
    apb(1'b1, ADDR_CMP[0], 32'h4);
    apb(1'b1, ADDR_CTRL[0], cw(1'b0, 3'h3, 1'b1, MODE_DIV));
    wait_irq(0, 80, n);
    check("divider match", 32'h1, {31'h0, n < 80});
    for (int k = 0; k < 2; k++) begin
      p = dpin[0];
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (dpin[0] === p && n < 80);
    end
    check("half period", 32'd32, n);
    apb(1'b0, ADDR_STAT, 32'h0);
    f = rdat[STAT_FF_LSB];
    apb(1'b1, ADDR_CTRL[0], cw(f, 3'h3, 1'b0, MODE_DIV));
    p = dpin[0];
    check("pin is inverse", {31'h0, ~f}, {31'h0, p});
    repeat (40) @(posedge clk);
    check("pin held", {31'h0, p}, {31'h0, dpin[0]});
    // The load lands on the last edge of the write; look one edge later
    apb(1'b1, ADDR_CTRL[0], cw(1'b1, 3'h3, 1'b0, MODE_DIV));
    @(posedge clk);
    check("pin after set", 32'h0, {31'h0, dpin[0]});
    apb(1'b0, ADDR_STAT, 32'h0);
    check("flip-flop set", 32'h1, {31'h0, rdat[STAT_FF_LSB]});
    apb(1'b1, ADDR_CTRL[0], cw(1'b0, 3'h3, 1'b0, MODE_DIV));
    @(posedge clk);
    check("pin after clear", 32'h1, {31'h0, dpin[0]});
  endtask : t_div

  task automatic t_cmp_now();
    apb(1'b1, ADDR_CMP[0], 32'h80);
    apb(1'b1, ADDR_CTRL[0], cw(1'b0, 3'h3, 1'b1, MODE_TIMER));
    repeat (2) @(posedge clk);
    apb(1'b0, ADDR_STAT, 32'h0);
    apb(1'b1, ADDR_CMP[0], {24'h0, rdat[7:0] + 8'h03});
    wait_irq(0, 60, n);
    check("compare at once", 32'h1, {31'h0, n < 60});
    apb(1'b1, ADDR_CTRL[0], 32'h0);
  endtask : t_cmp_now

  // Upper select is slow on purpose; only the lower one may be used
  task automatic t_cascade();
    apb(1'b1, ADDR_CMP[0], 32'h2);
    apb(1'b1, ADDR_CMP[1], 32'h1);
    apb(1'b1, ADDR_CTRL[0], cw(1'b0, 3'h6, 1'b0, MODE_TIMER));
    apb(1'b1, ADDR_CTRL[1], cw(1'b0, 3'h0, 1'b1, 3'h4));
    wait_irq(1, 600, n);
    wait_irq(1, 600, n);
    check("cascade period", 32'd258, n);
    apb(1'b1, ADDR_CTRL[1], 32'h0);
    for (int m = 2; m < 4; m++) begin
      apb(1'b1, ADDR_CTRL[0], cw(1'b0, 3'h6, 1'b1, 3'(m)));
      wait_irq(0, 50, n);
      check("no count in mode", 32'd50, n);
    end
    apb(1'b1, ADDR_CTRL[0], 32'h0);
  endtask : t_cascade

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    clk        = 1'b0;
    rst        = 1'b1;
    {psel, penable, pwrite, low_speed} = 4'h0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    fire       = 2'h0;
    hold       = 4'h2;
    fail_count = 0;
    n_tests    = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_sources();
    t_stop();
    t_event();
    t_div();
    t_cmp_now();
    t_cascade();
    close_out();
  end
endmodule : tdiv_top_test
